/* File: timer_pkg.sv */
// Shared constants and carrier types of the dual timer/counter block.
package timer_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] RUN_CTRL_ADDR   = 8'h88;
    localparam logic [7:0] MODE_CTRL_ADDR  = 8'h89;
    localparam logic [7:0] CNT_A_LO_ADDR   = 8'h8a;
    localparam logic [7:0] CNT_B_LO_ADDR   = 8'h8b;
    localparam logic [7:0] CNT_A_HI_ADDR   = 8'h8c;
    localparam logic [7:0] CNT_B_HI_ADDR   = 8'h8d;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'ha0;
    localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'ha1;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'ha2;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] RUN_RESET   = 8'h00;
    localparam logic [2:0] IRQ_RESET   = 3'h0;
    localparam logic [3:0] PINS_IDLE   = 4'hf;
    localparam int         TICK_DIV    = 2;
    localparam int         PRESCALE_W  = 5;

    // ************************************************************
    // Field layouts, most significant bit first
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'h0,
        MODE_WIDE     = 2'h1,
        MODE_RELOAD   = 2'h2,
        MODE_SPLIT    = 2'h3
    } cnt_mode_t;

    typedef struct packed {
        logic      cnt_b_pin_gating;
        logic      cnt_b_source_select;
        cnt_mode_t cnt_b_mode_field;
        logic      cnt_a_pin_gating;
        logic      cnt_a_source_select;
        cnt_mode_t cnt_a_mode_field;
    } mode_ctrl_t;

    typedef struct packed {
        logic       cnt_b_overflow_flag;
        logic       cnt_b_run;
        logic       cnt_a_overflow_flag;
        logic       cnt_a_run;
        logic [1:0] spare;
        logic       ext_irq_a_edge_flag;
        logic       ext_irq_a_trigger_select;
    } run_ctrl_t;

    typedef struct packed {
        logic ext_a;
        logic cnt_b;
        logic cnt_a;
    } irq_bits_t;

    typedef struct packed {
        logic ext_irq_a;
        logic ext_irq_b;
        logic cnt_a_count;
        logic cnt_b_count;
    } pins_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } count_pair_t;

    typedef struct packed {
        logic        ovf;
        count_pair_t cnt;
    } step_t;

    typedef struct packed {
        mode_ctrl_t  mode;
        run_ctrl_t   run;
        count_pair_t cnt_a;
        count_pair_t cnt_b;
        irq_bits_t   status;
        irq_bits_t   enable;
        pins_t       pins_prev;
        logic [7:0]  rdata;
        logic        irq;
    } timer_state_t;

endpackage

/* File: pin_sync.sv */
// Three-stage synchroniser with agreement filter for external pins.
`timescale 1ns/1ps

module pin_sync #(
    parameter int             WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Pins in, filtered levels out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    if (WIDTH < 1) begin : g_check
        $error("pin_sync needs at least one pin");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // A level is taken only once the last two stages agree, so a
    // pin caught mid-transition cannot produce a double edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
            dout   <= IDLE;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end

endmodule

/* File: tick_divider.sv */
// Divider that emits a one-cycle enable every DIV system clocks.
`timescale 1ns/1ps

module tick_divider #(
    parameter int DIV = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // One-cycle enable pulse
    output logic      tick
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    if (DIV < 2) begin : g_check
        $error("tick_divider needs a divisor of two or more");
    end

    logic [CW-1:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= (count == CW'(DIV - 1));
            if (count == CW'(DIV - 1)) begin
                count <= '0;
            end else begin
                count <= count + CW'(1);
            end
        end
    end

endmodule

/* File: timer_block.sv */
// Top of the dual timer/counter with external interrupt 0 logic.
`timescale 1ns/1ps

// Behaviour
// [RL1] Edge mode: falling edge sets flag, vector clears
// [RL2] Trigger select: 0 low level, 1 falling edge
// [RL3] Counter B gate: run, optionally pin B high
// [RL4] Counter B source: clock/2 or count-pin fall
// [RL5] Counter B modes 00 prescaled, 01 sixteen-bit
// [RL6] Counter B mode 10: low reloads from high
// [RL7] Counter B mode 11 holds its value
// [RL8] Counter A gate: run, optionally pin A high
// [RL9] Counter A source: clock/2 or count-pin fall
// [RL10] Counter A modes 00 prescaled, 01 sixteen-bit
// [RL11] Counter A mode 10: low reloads from high
// [RL12] Counter A mode 11: split, high uses B
// [RL13] Count bytes readable, writable, reset to zero
// [RL14] B overflow sets flag, vector clears it
// [RL15] A overflow sets flag, vector clears it
// [RL16] Run bits let counters advance or halt
// [RL17] Pins synchronised before edge detection
// [RL18] Overflow is wrap of the counting stage
module timer_block
    import timer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    // External pins
    input  wire logic       ext_irq_a_pin,
    input  wire logic       ext_irq_b_pin,
    input  wire logic       cnt_a_count_pin,
    input  wire logic       cnt_b_count_pin,
    // Vector acknowledges from the processor
    input  wire logic       vec_ext_a_ack,
    input  wire logic       vec_cnt_a_ack,
    input  wire logic       vec_cnt_b_ack,
    // Flags and interrupt
    output logic            ext_irq_a_edge_flag,
    output logic            cnt_a_overflow_flag,
    output logic            cnt_b_overflow_flag,
    output logic            irq
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ************************************************************
    // Pin synchronisation and time base
    // ************************************************************
    pins_t pins_raw;
    pins_t pins;
    logic  tick;

    assign pins_raw = '{ext_irq_a:   ext_irq_a_pin,
                        ext_irq_b:   ext_irq_b_pin,
                        cnt_a_count: cnt_a_count_pin,
                        cnt_b_count: cnt_b_count_pin};

    pin_sync #(
        .WIDTH (4),
        .IDLE  (PINS_IDLE)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (pins_raw),
        .dout  (pins)
    ); // RL17

    tick_divider #(
        .DIV   (TICK_DIV)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // ************************************************************
    // Count step
    // ************************************************************
    // The three upper bits of the low byte are left untouched in the
    // prescaled mode; software may use or clear them as it likes.
    function automatic step_t step_count(input cnt_mode_t   m,
                                         input count_pair_t c,
                                         input logic        inc);
        step_t       s;
        logic [13:0] p13;
        logic [16:0] p16;
        logic [8:0]  p8;
        s   = '{ovf: 1'b0, cnt: c};
        p13 = {1'b0, c.hi, c.lo[PRESCALE_W-1:0]} + 14'h0001;
        p16 = {1'b0, c} + 17'h00001;
        p8  = {1'b0, c.lo} + 9'h001;
        if (inc) begin
            case (m)
                MODE_PRESCALE: begin
                    s.cnt.hi               = p13[12:5];
                    s.cnt.lo[PRESCALE_W-1:0] = p13[4:0];
                    s.ovf                  = p13[13]; // RL18
                end
                MODE_WIDE: begin
                    s.cnt = p16[15:0];
                    s.ovf = p16[16]; // RL18
                end
                MODE_RELOAD: begin
                    s.cnt.lo = p8[8] ? c.hi : p8[7:0];
                    s.ovf    = p8[8]; // RL18
                end
                MODE_SPLIT: begin
                    s.cnt.lo = p8[7:0];
                    s.ovf    = p8[8]; // RL18
                end
                default: begin
                    s = '{ovf: 1'b0, cnt: c};
                end
            endcase
        end
        return s;
    endfunction

    // ************************************************************
    // State update
    // ************************************************************
    timer_state_t st_reg;
    timer_state_t st_next;

    logic        a_gate_ok;
    logic        b_gate_ok;
    logic        a_inc;
    logic        b_inc;
    logic        a_hi_inc;
    logic        a_fall;
    logic        b_fall;
    logic        ext_fall;
    logic        a_ovf;
    logic        b_ovf;
    logic        ext_set;
    logic [8:0]  a_hi_sum;
    step_t       a_step;
    step_t       b_step;
    logic        wr_run;
    irq_bits_t   events;
    irq_bits_t   clr_bits;

    always_comb begin
        st_next = st_reg;

        ext_fall = st_reg.pins_prev.ext_irq_a & ~pins.ext_irq_a;
        a_fall   = st_reg.pins_prev.cnt_a_count & ~pins.cnt_a_count;
        b_fall   = st_reg.pins_prev.cnt_b_count & ~pins.cnt_b_count;

        a_gate_ok = st_reg.run.cnt_a_run &
                    (~st_reg.mode.cnt_a_pin_gating | pins.ext_irq_a);
        // RL8 RL16
        b_gate_ok = st_reg.run.cnt_b_run &
                    (~st_reg.mode.cnt_b_pin_gating | pins.ext_irq_b);
        // RL3 RL16

        a_inc = a_gate_ok &
                (st_reg.mode.cnt_a_source_select ? a_fall : tick); // RL9
        b_inc = b_gate_ok &
                (st_reg.mode.cnt_b_source_select ? b_fall : tick); // RL4
        if (st_reg.mode.cnt_b_mode_field == MODE_SPLIT) begin
            b_inc = 1'b0; // RL7
        end

        a_step = step_count(st_reg.mode.cnt_a_mode_field, st_reg.cnt_a,
                            a_inc); // RL10 RL11
        b_step = step_count(st_reg.mode.cnt_b_mode_field, st_reg.cnt_b,
                            b_inc); // RL5 RL6

        // In split mode the high byte of A is a plain timer on B's run
        // bit and takes over B's overflow flag.
        a_hi_inc = st_reg.run.cnt_b_run & tick;
        a_hi_sum = {1'b0, st_reg.cnt_a.hi} + 9'h001;
        a_ovf    = a_step.ovf;
        b_ovf    = b_step.ovf;
        if (st_reg.mode.cnt_a_mode_field == MODE_SPLIT) begin
            b_ovf = a_hi_inc & a_hi_sum[8]; // RL12
            if (a_hi_inc) begin
                a_step.cnt.hi = a_hi_sum[7:0]; // RL12
            end
        end

        st_next.cnt_a = a_step.cnt;
        st_next.cnt_b = b_step.cnt;

        // Software writes to the count bytes win over counting.
        if (wr_en) begin
            case (addr)
                CNT_A_LO_ADDR: st_next.cnt_a.lo = wdata; // RL13
                CNT_A_HI_ADDR: st_next.cnt_a.hi = wdata; // RL13
                CNT_B_LO_ADDR: st_next.cnt_b.lo = wdata; // RL13
                CNT_B_HI_ADDR: st_next.cnt_b.hi = wdata; // RL13
                MODE_CTRL_ADDR: st_next.mode = mode_ctrl_t'(wdata);
                IRQ_ENABLE_ADDR: st_next.enable = irq_bits_t'(wdata[2:0]);
                default: begin
                end
            endcase
        end

        // Control bits: software write, then vector clear, then the
        // hardware set, so an event in the clearing cycle is kept.
        wr_run = wr_en & (addr == RUN_CTRL_ADDR);
        if (wr_run) begin
            st_next.run = run_ctrl_t'(wdata);
            st_next.run.spare = 2'h0;
        end
        if (vec_cnt_a_ack) begin
            st_next.run.cnt_a_overflow_flag = 1'b0; // RL15
        end
        if (vec_cnt_b_ack) begin
            st_next.run.cnt_b_overflow_flag = 1'b0; // RL14
        end
        if (a_ovf) begin
            st_next.run.cnt_a_overflow_flag = 1'b1; // RL15
        end
        if (b_ovf) begin
            st_next.run.cnt_b_overflow_flag = 1'b1; // RL14
        end

        // Level mode shows the inverted pin; edge mode latches falls.
        ext_set = 1'b0;
        if (st_next.run.ext_irq_a_trigger_select) begin
            if (vec_ext_a_ack) begin
                st_next.run.ext_irq_a_edge_flag = 1'b0; // RL1
            end
            if (ext_fall) begin
                st_next.run.ext_irq_a_edge_flag = 1'b1; // RL1
                ext_set = 1'b1;
            end
        end else begin
            st_next.run.ext_irq_a_edge_flag = ~pins.ext_irq_a; // RL2
            ext_set = ~pins.ext_irq_a;
        end

        // Sticky interrupt status; write-one clear loses to a new event.
        events   = '{ext_a: ext_set, cnt_b: b_ovf, cnt_a: a_ovf};
        clr_bits = irq_bits_t'(3'h0);
        if (wr_en && (addr == IRQ_CLEAR_ADDR)) begin
            clr_bits = irq_bits_t'(wdata[2:0]);
        end
        st_next.status = (st_reg.status & ~clr_bits) | events;
        st_next.irq    = |(st_next.status & st_next.enable);

        st_next.pins_prev = pins;

        // Read data stand for one cycle after the strobe only.
        st_next.rdata = 8'h00;
        if (rd_en) begin
            case (addr)
                RUN_CTRL_ADDR:   st_next.rdata = st_reg.run;
                MODE_CTRL_ADDR:  st_next.rdata = st_reg.mode;
                CNT_A_LO_ADDR:   st_next.rdata = st_reg.cnt_a.lo; // RL13
                CNT_A_HI_ADDR:   st_next.rdata = st_reg.cnt_a.hi; // RL13
                CNT_B_LO_ADDR:   st_next.rdata = st_reg.cnt_b.lo; // RL13
                CNT_B_HI_ADDR:   st_next.rdata = st_reg.cnt_b.hi; // RL13
                IRQ_STATUS_ADDR: st_next.rdata = {5'h00, st_reg.status};
                IRQ_ENABLE_ADDR: st_next.rdata = {5'h00, st_reg.enable};
                default:         st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{mode:      mode_ctrl_t'(MODE_RESET),
                        run:       run_ctrl_t'(RUN_RESET),
                        cnt_a:     '{hi: COUNT_RESET, lo: COUNT_RESET},
                        cnt_b:     '{hi: COUNT_RESET, lo: COUNT_RESET},
                        status:    irq_bits_t'(IRQ_RESET),
                        enable:    irq_bits_t'(IRQ_RESET),
                        pins_prev: pins_t'(PINS_IDLE),
                        rdata:     8'h00,
                        irq:       1'b0}; // RL13
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata               = st_reg.rdata;
    assign irq                 = st_reg.irq;
    assign ext_irq_a_edge_flag = st_reg.run.ext_irq_a_edge_flag;
    assign cnt_a_overflow_flag = st_reg.run.cnt_a_overflow_flag;
    assign cnt_b_overflow_flag = st_reg.run.cnt_b_overflow_flag;

endmodule

/* File: timer_chk.sv */
// Port-level assertions for the dual timer block.
`timescale 1ns/1ps

module timer_chk
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // Pins and vector acknowledges
    input wire logic       ext_irq_a_pin,
    input wire logic       vec_cnt_a_ack,
    input wire logic       vec_cnt_b_ack,
    // Flags and interrupt
    input wire logic       ext_irq_a_edge_flag,
    input wire logic       cnt_a_overflow_flag,
    input wire logic       cnt_b_overflow_flag,
    input wire logic       irq
);
    // Cycles since the pin was last low; covers the synchroniser delay.
    logic [3:0] low_age_reg;
    logic       any_flag;
    assign any_flag = ext_irq_a_edge_flag | cnt_a_overflow_flag
                      | cnt_b_overflow_flag;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            low_age_reg <= 4'h0;
        else if (!ext_irq_a_pin)
            low_age_reg <= 4'h0;
        else if (low_age_reg != 4'hf)
            low_age_reg <= low_age_reg + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_rdata_idle;
        !rd_en |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    property p_hole_read;
        rd_en && (addr == 8'h00 || addr == IRQ_CLEAR_ADDR) |=> rdata == 8'h00;
    endproperty
    a_hole_read: assert property (p_hole_read)
        else $error("unmapped read not zero");
    property p_mode_rw;
        wr_en && addr == MODE_CTRL_ADDR ##1 rd_en && addr == MODE_CTRL_ADDR
            |=> rdata == $past(wdata, 2);
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("mode byte read back differs");
    property p_a_fall;
        $fell(cnt_a_overflow_flag) |-> $past(vec_cnt_a_ack) || $past(wr_en);
    endproperty
    a_a_fall: assert property (p_a_fall)
        else $error("counter A flag cleared without cause");
    property p_b_fall;
        $fell(cnt_b_overflow_flag) |-> $past(vec_cnt_b_ack) || $past(wr_en);
    endproperty
    a_b_fall: assert property (p_b_fall)
        else $error("counter B flag cleared without cause");
    property p_a_hold;
        cnt_a_overflow_flag && !vec_cnt_a_ack && !wr_en
            |=> cnt_a_overflow_flag;
    endproperty
    a_a_hold: assert property (p_a_hold)
        else $error("counter A flag not sticky");
    property p_b_hold;
        cnt_b_overflow_flag && !vec_cnt_b_ack && !wr_en
            |=> cnt_b_overflow_flag;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("counter B flag not sticky");
    property p_edge_cause;
        $rose(ext_irq_a_edge_flag) && !$past(wr_en) |-> low_age_reg <= 4'h8;
    endproperty
    a_edge_cause: assert property (p_edge_cause)
        else $error("edge flag set without a low pin");
    property p_irq_cause;
        $rose(irq) |-> any_flag || $past(wr_en) || $past(wr_en, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt raised without cause");
endmodule

bind timer_block timer_chk timer_chk_i (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_irq_a_pin(ext_irq_a_pin), .vec_cnt_a_ack(vec_cnt_a_ack),
    .vec_cnt_b_ack(vec_cnt_b_ack), .ext_irq_a_edge_flag(ext_irq_a_edge_flag),
    .cnt_a_overflow_flag(cnt_a_overflow_flag),
    .cnt_b_overflow_flag(cnt_b_overflow_flag), .irq(irq)
);

/* File: pin_model.sv */
// Model of the external count and gate pins, idle high by pull-up.
`timescale 1ns/1ps

module pin_model
    import timer_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Pin levels
    output pins_t     pins
);
    initial pins = PINS_IDLE;
    task set(input int i, input logic v);
        @(posedge clk);
        pins[i] <= v;
        #1;
    endtask
    // Each level stays five clocks so the pin filter always sees it.
    task pulse(input int i, input int n);
        repeat (n) begin
            set(i, 1'b0);
            repeat (4) @(posedge clk);
            set(i, 1'b1);
            repeat (4) @(posedge clk);
        end
        #1;
    endtask
endmodule

/* File: tb.sv */
// Self-checking testbench of the dual timer block.
`timescale 1ns/1ps

module tb;
    logic       clk;
    logic       reset_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rdata;
    logic [2:0] vec_ack;
    logic [2:0] fl;
    logic       irq;
    logic [7:0] v;
    int         err_total;
    int         checks;
    timer_pkg::pins_t pins;

    timer_block timer_block_i (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_irq_a_pin(pins.ext_irq_a), .ext_irq_b_pin(pins.ext_irq_b),
        .cnt_a_count_pin(pins.cnt_a_count),
        .cnt_b_count_pin(pins.cnt_b_count),
        .vec_ext_a_ack(vec_ack[2]), .vec_cnt_a_ack(vec_ack[0]),
        .vec_cnt_b_ack(vec_ack[1]), .ext_irq_a_edge_flag(fl[2]),
        .cnt_a_overflow_flag(fl[0]), .cnt_b_overflow_flag(fl[1]), .irq(irq)
    );
    pin_model pin_model_i (.clk(clk), .pins(pins));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task stop_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", n, exp, got);
            err_total++;
        end
    endtask
    // Every task starts and ends 1 ns after a rising edge.
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk("register", d, exp);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task ack(input int i);
        vec_ack[i] <= 1'b1;
        @(posedge clk);
        vec_ack <= 3'h0;
        #1;
    endtask
    task wait_hi(input int i);
        int n;
        n = 0;
        while (fl[i] !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("flag", {7'h0, fl[i]}, 8'h01);
        if (fl[i] !== 1'b1)
            stop_test();
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        vec_ack = 3'h0;
        err_total = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        cyc(4);
        rdc(8'h8a, 8'h00);
        rdc(8'h8b, 8'h00);
        rdc(8'h8c, 8'h00);
        rdc(8'h8d, 8'h00);
        rdc(8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h8a + 8'(i), 8'h11 * 8'(i + 1));
            rdc(8'h8a + 8'(i), 8'h11 * 8'(i + 1));
        end
        wr(8'h89, 8'ha5);
        rdc(8'h89, 8'ha5);
        $display("test registers done");
        wr(8'h89, 8'h05);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        pin_model_i.pulse(1, 1);
        chk("no flag", {7'h0, fl[0]}, 8'h00);
        pin_model_i.pulse(1, 1);
        wait_hi(0);
        rdc(8'h8a, 8'h00);
        rdc(8'h8c, 8'h00);
        rdc(8'ha0, 8'h01);
        chk("irq masked", {7'h0, irq}, 8'h00);
        wr(8'ha2, 8'h01);
        cyc(2);
        chk("irq", {7'h0, irq}, 8'h01);
        ack(0);
        chk("ack", {7'h0, fl[0]}, 8'h00);
        wr(8'ha1, 8'h01);
        cyc(2);
        chk("irq clear", {7'h0, irq}, 8'h00);
        wr(8'ha2, 8'h00);
        $display("test wide count done");
        wr(8'h89, 8'h04);
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'hff);
        pin_model_i.pulse(1, 1);
        wait_hi(0);
        rdc(8'h8c, 8'h00);
        rdc(8'h8a, 8'he0);
        pin_model_i.pulse(1, 1);
        rdc(8'h8a, 8'he1);
        $display("test prescale done");
        wr(8'h89, 8'h0d);
        wr(8'h8a, 8'h00);
        pin_model_i.set(3, 1'b0);
        pin_model_i.pulse(1, 2);
        rdc(8'h8a, 8'h00);
        pin_model_i.set(3, 1'b1);
        pin_model_i.pulse(1, 2);
        rdc(8'h8a, 8'h02);
        wr(8'h88, 8'h00);
        pin_model_i.pulse(1, 1);
        rdc(8'h8a, 8'h02);
        wr(8'h89, 8'h06);
        wr(8'h8c, 8'hf0);
        wr(8'h8a, 8'hff);
        wr(8'h88, 8'h10);
        pin_model_i.pulse(1, 1);
        wait_hi(0);
        rdc(8'h8a, 8'hf0);
        rdc(8'h8c, 8'hf0);
        wr(8'h88, 8'h00);
        $display("test gate A done");
        wr(8'h88, 8'h01);
        pin_model_i.pulse(3, 1);
        wait_hi(2);
        ack(2);
        chk("edge ack", {7'h0, fl[2]}, 8'h00);
        wr(8'h88, 8'h00);
        pin_model_i.set(3, 1'b0);
        cyc(8);
        chk("level", {7'h0, fl[2]}, 8'h01);
        pin_model_i.set(3, 1'b1);
        cyc(8);
        chk("level off", {7'h0, fl[2]}, 8'h00);
        wr(8'ha1, 8'h07);
        $display("test external done");
        wr(8'h89, 8'h10);
        wr(8'h8b, 8'h00);
        wr(8'h8d, 8'h00);
        wr(8'h88, 8'h40);
        cyc(40);
        wr(8'h88, 8'h00);
        rd(8'h8b, v);
        chk("rate", {7'h0, v >= 8'h12 && v <= 8'h17}, 8'h01);
        wr(8'h89, 8'h20);
        wr(8'h8d, 8'hf0);
        wr(8'h8b, 8'hfe);
        wr(8'h88, 8'h40);
        wait_hi(1);
        wr(8'h88, 8'h00);
        rd(8'h8b, v);
        chk("reload", v & 8'hf0, 8'hf0);
        rdc(8'h8d, 8'hf0);
        wr(8'h8b, 8'h33);
        wr(8'h89, 8'h30);
        wr(8'h88, 8'h40);
        cyc(20);
        rdc(8'h8b, 8'h33);
        wr(8'h89, 8'h40);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'h3f);
        pin_model_i.pulse(0, 1);
        wait_hi(1);
        rdc(8'h8d, 8'h00);
        rdc(8'h8b, 8'h20);
        $display("test counter B done");
        wr(8'h89, 8'hd0);
        wr(8'h8b, 8'h00);
        pin_model_i.set(2, 1'b0);
        pin_model_i.pulse(0, 2);
        rdc(8'h8b, 8'h00);
        pin_model_i.set(2, 1'b1);
        pin_model_i.pulse(0, 2);
        rdc(8'h8b, 8'h02);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h37);
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'hfe);
        wr(8'h88, 8'h10);
        pin_model_i.pulse(1, 1);
        wait_hi(0);
        rdc(8'h8a, 8'h00);
        rdc(8'h8c, 8'hfe);
        wr(8'h88, 8'h40);
        wait_hi(1);
        $display("test split done");
        stop_test();
    end
endmodule
